// >>> verilog/pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define PIC_IDX_EDGE 8'h88
`define PIC_IDX_PRIO0 8'h8a
`define PIC_IDX_PRIO1 8'h8b
`define PIC_IDX_PRIO2 8'h8c
`define PIC_IDX_PRIO3 8'h8d
`define PIC_IDX_GATES 8'ha8
`define PIC_IDX_PIN_GATES 8'hd1
`define PIC_IDX_PIN_PEND 8'hd2
`define PIC_IDX_UART 8'he0
`define PIC_IDX_EXT_A 8'he1
`define PIC_IDX_INSERVICE 8'he2

// ----------------------------------------
// field positions
// ----------------------------------------
`define PIC_GATE_GLOBAL 7
`define PIC_GATE_CLOCK_ALARM 6
`define PIC_GATE_MISSING_CLOCK 5
`define PIC_GATE_UART 4
`define PIC_GATE_SPI 3
`define PIC_GATE_EXT_B 2
`define PIC_GATE_THERMAL 1
`define PIC_GATE_EXT_A 0
`define PIC_EDGE_A_LSB 0
`define PIC_EDGE_B_LSB 3
`define PIC_EDGE_WR_MASK 5'h1b
`define PIC_EXT_A_PEND_BIT 0
`define PIC_EXT_A_SEL_LSB 1
`define PIC_UART_RX_BIT 0
`define PIC_UART_TX_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define PIC_EDGE_RST 5'h00
`define PIC_PRIO_RST 32'h0000_0000
`define PIC_GATES_RST 8'h00
`define PIC_PIN_GATES_RST 8'h00
`define PIC_PIN_PEND_RST 8'h00

// ----------------------------------------
// vectors
// ----------------------------------------
`define PIC_VEC_RESET 16'h0000
`define PIC_VEC_BASE 16'h0003
`define PIC_VEC_LAST 16'h007b

`endif

// >>> verilog/pic_pkg.sv
package pic_pkg;

	typedef enum logic [1:0] {
		PIC_EDGE_RISE = 2'b00,
		PIC_EDGE_FALL = 2'b01,
		PIC_EDGE_BOTH = 2'b10,
		PIC_EDGE_ANY = 2'b11
	} pic_edge_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} pic_sync_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [4:0] edge_sel;
		logic [31:0] prio;
		logic [7:0] gates;
		logic [7:0] pin_gates;
		logic [7:0] pin_pend;
		logic ext_a_pend;
		logic [2:0] pin_sel;
		logic [1:0] uart;
		logic [3:0] isr;
		logic req;
		logic [3:0] src;
		logic [1:0] lvl;
		logic [15:0] vec;
	} pic_state_t;

endpackage

// >>> verilog/pic_edge_detect.sv
module pic_edge_detect (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// pin and mode
	input wire logic pin_i,
	input wire pic_pkg::pic_edge_t mode_i,
	// detected edge
	output logic edge_o
);
	import pic_pkg::*;

	pic_sync_t st_q;
	pic_sync_t st_d;

	always_comb begin
		st_d.s1 = pin_i;
		st_d.s2 = st_q.s1;
		st_d.prev = st_q.s2;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// edge select decode
	always_comb begin
		case (mode_i)
			PIC_EDGE_RISE: begin
				edge_o = st_q.s2 & ~st_q.prev;
			end
			PIC_EDGE_FALL: begin
				edge_o = ~st_q.s2 & st_q.prev;
			end
			default: begin
				edge_o = st_q.s2 ^ st_q.prev;
			end
		endcase
	end

	a_rise_only: assert property (@(posedge ref_clk) disable iff (rst)
		(edge_o && mode_i == PIC_EDGE_RISE) |-> (st_q.s2 && !st_q.prev))
		else $error("rising mode fired without a rising edge");
	a_fall_only: assert property (@(posedge ref_clk) disable iff (rst)
		(edge_o && mode_i == PIC_EDGE_FALL) |-> (!st_q.s2 && st_q.prev))
		else $error("falling mode fired without a falling edge");
endmodule

// >>> verilog/pic_arbiter.sv
module pic_arbiter (
	// requests and levels
	input wire logic [15:0] active_i,
	input wire logic [31:0] prio_i,
	// winner
	output logic valid_o,
	output logic [3:0] idx_o,
	output logic [1:0] lvl_o
);
	import pic_pkg::*;

	// scan from top index down so a lower index wins a tie
	always_comb begin
		valid_o = 1'b0;
		idx_o = 4'h0;
		lvl_o = 2'h0;
		for (int i = 15; i >= 0; i--) begin
			if (active_i[i] && (!valid_o || prio_i[2*i +: 2] >= lvl_o)) begin
				valid_o = 1'b1;
				idx_o = 4'(i);
				lvl_o = prio_i[2*i +: 2];
			end
		end
	end
endmodule

// >>> verilog/pic_ctrl.sv
`include "pic_regs.svh"

// Behaviour
// - sixteen sources, each with its own two-bit priority slot
// - hardware sets a pending flag on pin edges and uart done; other sources request at their input level
// - request only when global gate, source gate and flag are all one
// - higher level preempts; equal level never; lower resumes after higher finishes
// - levels 0 lowest to 3 highest; all priority fields reset to 0
// - highest level wins; ties go to the lower source index
// - flags set while disabled stay pending and request once enabled
// - edge select: 00 rising, 01 falling, 1x both; fields [1:0] and [4:3]
// - external A: one pin of eight by select, one vector, flag, gate
// - external B: eight pins, own flags and gates, one vector and group gate
// - reset vector 0x0000; sources from 0x0003 in steps of eight to 0x007b
// - reset is always enabled, has no flag and no priority field
// - priority registers hold four fields, source 0 in the lowest
// - shared sources merge into one vector and priority slot; a periph_flag_i input keeps its own periph_gate_i gate
// - ordinary flags clear on written 0; written 1 does nothing
// - uart done flags may also be set by software and then request
// - gate register: global at bit 7, then seven gates down to 0, bit 5 the missing clock gate output
// - pin gate bits 7..0 map to the eight external B pins
// - pin pending register uses the same map and resets to zero
module pic_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// peripheral sources
	input wire logic [15:0] periph_flag_i,
	input wire logic [15:0] periph_gate_i,
	input wire logic thermal_shutdown_i,
	input wire logic clock_alarm_i,
	input wire logic spi_flag_i,
	input wire logic uart_rx_done_i,
	input wire logic uart_tx_done_i,
	// external pins
	input wire logic [7:0] ext_a_irq_i,
	input wire logic [7:0] ext_b_irq_i,
	// cpu side
	input wire logic irq_take_i,
	input wire logic irq_done_i,
	output logic irq_req_o,
	output logic [15:0] irq_vector_o,
	output logic [1:0] irq_level_o,
	// status to peripherals
	output logic [1:0] uart_done_flags_o,
	output logic missing_clock_gate_o
);
	import pic_pkg::*;

	pic_state_t st_q;
	pic_state_t st_d;

	logic acc;
	logic wr;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [8:0] edge_pin;
	logic [8:0] edge_hit;
	logic [15:0] active;
	logic win_valid;
	logic [3:0] win_idx;
	logic [1:0] win_lvl;
	logic ext_a_pin;
	logic [3:0] isr_top;
	logic take;
	logic win_ok;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign acc = wb_cyc_i & wb_stb_i & ~st_q.ack;
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[9:2];
	assign wdat = wb_dat_i[7:0];
	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = {24'h000000, st_q.rdata};

	// ----------------------------------------
	// pin edge detection
	// ----------------------------------------
	assign ext_a_pin = ext_a_irq_i[st_q.pin_sel];

	generate
		for (genvar g = 0; g < 9; g++) begin : g_pin
			if (g == 0) begin : g_a
				assign edge_pin[g] = ext_a_pin;
				pic_edge_detect u_edge (
					.ref_clk(ref_clk),
					.rst(rst),
					.pin_i(edge_pin[g]),
					.mode_i(pic_edge_t'(st_q.edge_sel[`PIC_EDGE_A_LSB +: 2])),
					.edge_o(edge_hit[g])
				);
			end else begin : g_b
				assign edge_pin[g] = ext_b_irq_i[g-1];
				pic_edge_detect u_edge (
					.ref_clk(ref_clk),
					.rst(rst),
					.pin_i(edge_pin[g]),
					.mode_i(pic_edge_t'(st_q.edge_sel[`PIC_EDGE_B_LSB +: 2])),
					.edge_o(edge_hit[g])
				);
			end
		end
	endgenerate

	// ----------------------------------------
	// per-source requests
	// ----------------------------------------
	always_comb begin
		active = periph_flag_i & periph_gate_i;
		active[0] = active[0] | (thermal_shutdown_i & st_q.gates[`PIC_GATE_THERMAL]);
		active[1] = active[1] | (st_q.ext_a_pend & st_q.gates[`PIC_GATE_EXT_A]);
		active[2] = active[2] | ((|(st_q.pin_pend & st_q.pin_gates)) & st_q.gates[`PIC_GATE_EXT_B]);
		active[8] = active[8] | (clock_alarm_i & st_q.gates[`PIC_GATE_CLOCK_ALARM]);
		active[13] = active[13] | ((|st_q.uart) & st_q.gates[`PIC_GATE_UART]);
		active[14] = active[14] | (spi_flag_i & st_q.gates[`PIC_GATE_SPI]);
		active = active & {16{st_q.gates[`PIC_GATE_GLOBAL]}};
	end

	pic_arbiter u_arb (
		.active_i(active),
		.prio_i(st_q.prio),
		.valid_o(win_valid),
		.idx_o(win_idx),
		.lvl_o(win_lvl)
	);

	// ----------------------------------------
	// independent winner check
	// ----------------------------------------
	// drops win_ok when some active source should have beaten the pick
	always_comb begin
		win_ok = win_valid;
		for (int i = 0; i < 16; i++) begin
			if (active[i] && (st_q.prio[2*i +: 2] > win_lvl ||
				(st_q.prio[2*i +: 2] == win_lvl && 4'(i) < win_idx))) begin
				win_ok = 1'b0;
			end
		end
	end

	// highest in-service level, one-hot
	always_comb begin
		isr_top = 4'h0;
		for (int l = 0; l < 4; l++) begin
			if (st_q.isr[l]) begin
				isr_top = 4'h1 << l;
			end
		end
	end

	assign take = irq_take_i & st_q.req;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.ack = acc;
		if (acc) begin
			if (idx == `PIC_IDX_EDGE) begin
				st_d.rdata = {3'h0, st_q.edge_sel};
			end else if (idx == `PIC_IDX_PRIO0) begin
				st_d.rdata = st_q.prio[7:0];
			end else if (idx == `PIC_IDX_PRIO1) begin
				st_d.rdata = st_q.prio[15:8];
			end else if (idx == `PIC_IDX_PRIO2) begin
				st_d.rdata = st_q.prio[23:16];
			end else if (idx == `PIC_IDX_PRIO3) begin
				st_d.rdata = st_q.prio[31:24];
			end else if (idx == `PIC_IDX_GATES) begin
				st_d.rdata = st_q.gates;
			end else if (idx == `PIC_IDX_PIN_GATES) begin
				st_d.rdata = st_q.pin_gates;
			end else if (idx == `PIC_IDX_PIN_PEND) begin
				st_d.rdata = st_q.pin_pend;
			end else if (idx == `PIC_IDX_UART) begin
				st_d.rdata = {6'h00, st_q.uart};
			end else if (idx == `PIC_IDX_EXT_A) begin
				st_d.rdata = {4'h0, st_q.pin_sel, st_q.ext_a_pend};
			end else if (idx == `PIC_IDX_INSERVICE) begin
				st_d.rdata = {4'h0, st_q.isr};
			end else begin
				st_d.rdata = 8'h00;
			end
			if (wb_adr_i[11:10] != 2'h0) begin
				st_d.rdata = 8'h00;
			end
		end
		if (wr && wb_adr_i[11:10] == 2'h0) begin
			if (idx == `PIC_IDX_EDGE) begin
				st_d.edge_sel = wdat[4:0] & `PIC_EDGE_WR_MASK;
			end else if (idx == `PIC_IDX_PRIO0) begin
				st_d.prio[7:0] = wdat;
			end else if (idx == `PIC_IDX_PRIO1) begin
				st_d.prio[15:8] = wdat;
			end else if (idx == `PIC_IDX_PRIO2) begin
				st_d.prio[23:16] = wdat;
			end else if (idx == `PIC_IDX_PRIO3) begin
				st_d.prio[31:24] = wdat;
			end else if (idx == `PIC_IDX_GATES) begin
				st_d.gates = wdat;
			end else if (idx == `PIC_IDX_PIN_GATES) begin
				st_d.pin_gates = wdat;
			end else if (idx == `PIC_IDX_PIN_PEND) begin
				st_d.pin_pend = st_q.pin_pend & wdat;
			end else if (idx == `PIC_IDX_UART) begin
				st_d.uart = wdat[1:0];
			end else if (idx == `PIC_IDX_EXT_A) begin
				st_d.ext_a_pend = st_q.ext_a_pend & wdat[`PIC_EXT_A_PEND_BIT];
				st_d.pin_sel = wdat[`PIC_EXT_A_SEL_LSB +: 3];
			end
		end
		// hardware set wins over a same-cycle clear
		st_d.pin_pend = st_d.pin_pend | edge_hit[8:1];
		st_d.ext_a_pend = st_d.ext_a_pend | edge_hit[0];
		st_d.uart = st_d.uart | {uart_tx_done_i, uart_rx_done_i};
		// nesting: finish pops the top level, take pushes the taken one
		if (irq_done_i) begin
			st_d.isr = st_q.isr & ~isr_top;
		end
		if (take) begin
			st_d.isr = st_d.isr | (4'h1 << st_q.lvl);
		end
		st_d.req = win_valid && ((st_d.isr & (4'hf << win_lvl)) == 4'h0);
		// vector and level keep their last value while nothing requests
		if (win_valid) begin
			st_d.src = win_idx;
			st_d.lvl = win_lvl;
			st_d.vec = 16'(`PIC_VEC_BASE + {9'h000, win_idx, 3'h0});
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.edge_sel <= `PIC_EDGE_RST;
			st_q.prio <= `PIC_PRIO_RST;
			st_q.gates <= `PIC_GATES_RST;
			st_q.pin_gates <= `PIC_PIN_GATES_RST;
			st_q.pin_pend <= `PIC_PIN_PEND_RST;
			st_q.vec <= `PIC_VEC_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign irq_req_o = st_q.req;
	assign irq_vector_o = st_q.vec;
	assign irq_level_o = st_q.lvl;
	assign uart_done_flags_o = st_q.uart;
	assign missing_clock_gate_o = st_q.gates[`PIC_GATE_MISSING_CLOCK];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ack_single: assert property (@(posedge ref_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_ack_next: assert property (@(posedge ref_clk) disable iff (rst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus access not acknowledged next cycle");
	a_req_gated: assert property (@(posedge ref_clk) disable iff (rst)
		irq_req_o |-> $past(st_q.gates[`PIC_GATE_GLOBAL]))
		else $error("request raised with global gate off");
	a_no_equal_preempt: assert property (@(posedge ref_clk) disable iff (rst)
		irq_req_o |-> ((st_q.isr & (4'hf << st_q.lvl)) == 4'h0))
		else $error("request at or below an in-service level");
	a_take_pushes: assert property (@(posedge ref_clk) disable iff (rst)
		(take && !irq_done_i) |=> st_q.isr[$past(st_q.lvl)] && (!irq_req_o || irq_level_o > $past(st_q.lvl)))
		else $error("taken level not marked in service");
	a_done_pops: assert property (@(posedge ref_clk) disable iff (rst)
		(irq_done_i && !take && st_q.isr != 4'h0) |=> ($countones(st_q.isr) == $countones($past(st_q.isr)) - 1))
		else $error("completion did not restore previous level");
	a_vector_map: assert property (@(posedge ref_clk) disable iff (rst)
		irq_req_o |-> (irq_vector_o == 16'(`PIC_VEC_BASE + {9'h000, st_q.src, 3'h0}) && irq_vector_o <= `PIC_VEC_LAST))
		else $error("vector outside the source table");
	a_win_level: assert property (@(posedge ref_clk) disable iff (rst)
		(|active) |-> (win_valid && active[win_idx] && win_ok && st_q.prio[2*win_idx +: 2] == win_lvl))
		else $error("arbiter winner inconsistent");
	generate
		for (genvar p = 0; p < 8; p++) begin : g_pin_chk
			a_edge_sets_pin: assert property (@(posedge ref_clk) disable iff (rst)
				edge_hit[p+1] |=> st_q.pin_pend[p])
				else $error("pin edge did not set its flag");
		end
	endgenerate
	a_write_one_keeps: assert property (@(posedge ref_clk) disable iff (rst)
		(wr && idx == `PIC_IDX_PIN_PEND && wb_adr_i[11:10] == 2'h0 && wdat == 8'hff && edge_hit[8:1] == 8'h00)
			|=> st_q.pin_pend == $past(st_q.pin_pend))
		else $error("writing one changed a pending flag");
	a_uart_soft_set: assert property (@(posedge ref_clk) disable iff (rst)
		(wr && idx == `PIC_IDX_UART && wb_adr_i[11:10] == 2'h0 && wdat[0]) |=> st_q.uart[0])
		else $error("software set of uart flag lost");
	a_req_rises: assert property (@(posedge ref_clk) disable iff (rst)
		(win_valid && st_q.isr == 4'h0 && !take) |=> irq_req_o)
		else $error("enabled pending source not requested");
	a_gate_blocks: assert property (@(posedge ref_clk) disable iff (rst)
		!st_q.gates[`PIC_GATE_GLOBAL] |=> !irq_req_o)
		else $error("request while global gate closed");
	a_ext_a_sets: assert property (@(posedge ref_clk) disable iff (rst)
		edge_hit[0] |=> st_q.ext_a_pend)
		else $error("external a edge did not set its flag");
	a_pend_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		(st_q.pin_pend != 8'h00 && !(wr && idx == `PIC_IDX_PIN_PEND))
			|=> ((st_q.pin_pend & $past(st_q.pin_pend)) == $past(st_q.pin_pend)))
		else $error("pending flag dropped without a write");
	a_clear_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(wr && idx == `PIC_IDX_PIN_PEND && wb_adr_i[11:10] == 2'h0 && wdat == 8'h00 && edge_hit[8:1] == 8'h00)
			|=> st_q.pin_pend == 8'h00)
		else $error("writing zero did not clear pending flags");
	a_uart_rx_hw: assert property (@(posedge ref_clk) disable iff (rst)
		uart_rx_done_i |=> st_q.uart[0])
		else $error("hardware set of uart rx flag lost");
	a_uart_tx_hw: assert property (@(posedge ref_clk) disable iff (rst)
		uart_tx_done_i |=> st_q.uart[1])
		else $error("hardware set of uart tx flag lost");
	a_prio_write: assert property (@(posedge ref_clk) disable iff (rst)
		(wr && idx == `PIC_IDX_PRIO0 && wb_adr_i[11:10] == 2'h0) |=> st_q.prio[7:0] == $past(wdat))
		else $error("priority field write lost");

	c_nested: cover property (@(posedge ref_clk) disable iff (rst) $countones(st_q.isr) >= 2);
	c_take: cover property (@(posedge ref_clk) disable iff (rst) take);
	c_pin_flag: cover property (@(posedge ref_clk) disable iff (rst) st_q.pin_pend != 8'h00);
	c_uart_req: cover property (@(posedge ref_clk) disable iff (rst) irq_req_o && st_q.src == 4'hd);
	c_ext_a: cover property (@(posedge ref_clk) disable iff (rst) st_q.ext_a_pend);
endmodule

// >>> verification/pic_cpu_model.sv
// ----------------------------------------
// cpu core servicing vectored requests
// ----------------------------------------
module pic_cpu_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// controller side
	input wire logic req,
	input wire logic [15:0] vector,
	output logic take,
	output logic done,
	// bench control
	input wire logic accept,
	input wire logic finish,
	output logic [15:0] last_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			take <= 1'b0;
			done <= 1'b0;
			last_vec <= 16'hffff;
		end else begin
			// one take per raised request, only while it stands
			take <= accept && req && !take;
			// return from routine on bench command
			done <= finish;
			if (take && req) begin
				last_vec <= vector;
			end
		end
	end
endmodule

// >>> verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, acc = 0, fin = 0;
	logic [11:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, dat_o;
	logic [15:0] flg = 0, gte = 16'hffff, vec, lvec;
	logic [7:0] apin = 0, bpin = 0, rdat;
	logic ack, req, take, done, mcg;
	logic thr = 0, alm = 0, spi = 0, urx = 0, utx = 0;
	logic [1:0] lvl, uflg;
	int miscompares = 0, compares = 0, cycles = 0;
	pic_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.periph_flag_i(flg), .periph_gate_i(gte), .thermal_shutdown_i(thr), .clock_alarm_i(alm),
		.spi_flag_i(spi), .uart_rx_done_i(urx), .uart_tx_done_i(utx), .ext_a_irq_i(apin),
		.ext_b_irq_i(bpin), .irq_take_i(take), .irq_done_i(done), .irq_req_o(req),
		.irq_vector_o(vec), .irq_level_o(lvl), .uart_done_flags_o(uflg), .missing_clock_gate_o(mcg));
	pic_cpu_model cpu (.ref_clk(ref_clk), .rst(rst), .req(req), .vector(vec), .take(take),
		.done(done), .accept(acc), .finish(fin), .last_vec(lvec));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// ----------------------------------------
	// wishbone classic master
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {2'b00, ix, 2'b00};
		dat <= {24'h000000, d};
		sel <= s;
		@(posedge ref_clk);
		// wait for the answer; only the cycle limit ends a hang
		while (ack !== 1'b1) begin
			@(posedge ref_clk);
		end
		rdat = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		bus(1'b1, ix, d, 4'h1);
	endtask
	task automatic rc(input logic [7:0] ix, input logic [7:0] exp);
		bus(1'b0, ix, 8'h00, 4'h1);
		cmp(rdat, exp);
	endtask
	task automatic fin_pulse();
		fin <= 1'b1;
		@(posedge ref_clk);
		fin <= 1'b0;
		tick(3);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] ix[9] = '{8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha8, 8'hd1, 8'hd2, 8'h55};
		foreach (ix[i]) rc(ix[i], 8'h00);
		cmp(vec, 16'h0000);
		bus(1'b1, 8'ha8, 8'hff, 4'h0);
		rc(8'ha8, 8'h00);
		wr(8'h55, 8'hff);
		rc(8'h55, 8'h00);
		wr(8'ha8, 8'h20);
		cmp(mcg, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_gate();
		wr(8'ha8, 8'h00);
		flg <= 16'h0020;
		tick(4);
		cmp(req, 1'b0);
		wr(8'ha8, 8'h80);
		tick(2);
		cmp(req, 1'b1);
		cmp(vec, 16'h002b);
		$display("test gate done");
	endtask
	task automatic t_arb();
		for (int i = 0; i < 16; i++) begin
			if (i != 1 && i != 2 && i != 8) begin
				flg <= 16'h0001 << i;
				tick(3);
				cmp(vec, 16'h0003 + 16'(8 * i));
			end
		end
		flg <= 16'h0210;
		tick(3);
		cmp(vec, 16'h0023);
		for (int j = 0; j < 4; j++) begin
			wr(8'h8a + 8'(j), 8'hc0);
			rc(8'h8a + 8'(j), 8'hc0);
			flg <= 16'h0001 | (16'h0008 << (4 * j));
			tick(3);
			cmp(vec, 16'h001b + 16'(32 * j));
			cmp(lvl, 2'd3);
			wr(8'h8a + 8'(j), 8'h00);
		end
		$display("test arbitration done");
	endtask
	task automatic t_nest();
		wr(8'h8c, 8'h08);
		flg <= 16'h0010;
		acc <= 1'b1;
		tick(4);
		cmp(lvec, 16'h0023);
		rc(8'he2, 8'h01);
		flg <= 16'h0210;
		tick(4);
		cmp(lvec, 16'h004b);
		rc(8'he2, 8'h05);
		cmp(req, 1'b0);
		flg <= 16'h0010;
		fin_pulse();
		cmp(req, 1'b0);
		rc(8'he2, 8'h01);
		acc <= 1'b0;
		fin_pulse();
		cmp(req, 1'b1);
		cmp(vec, 16'h0023);
		flg <= 16'h0000;
		$display("test nesting done");
	endtask
	task automatic t_ext_a();
		wr(8'ha8, 8'h81);
		wr(8'he1, 8'h04);
		tick(5);
		wr(8'he1, 8'h04);
		for (int m = 0; m < 4; m++) begin
			wr(8'h88, 8'(m));
			apin <= 8'h04;
			tick(5);
			rc(8'he1, (m != 1) ? 8'h05 : 8'h04);
			wr(8'he1, 8'h04);
			apin <= 8'h00;
			tick(5);
			rc(8'he1, (m != 0) ? 8'h05 : 8'h04);
			wr(8'he1, 8'h04);
		end
		$display("test ext a done");
	endtask
	task automatic t_ext_b();
		wr(8'h88, 8'h00);
		wr(8'ha8, 8'h84);
		wr(8'hd1, 8'h10);
		bpin <= 8'h90;
		tick(5);
		rc(8'hd2, 8'h90);
		cmp(vec, 16'h0013);
		wr(8'hd2, 8'h80);
		rc(8'hd2, 8'h80);
		cmp(req, 1'b0);
		wr(8'hd2, 8'hff);
		rc(8'hd2, 8'h80);
		wr(8'hd2, 8'h00);
		wr(8'h88, 8'h08);
		bpin <= 8'h00;
		tick(5);
		rc(8'hd2, 8'h90);
		$display("test ext b done");
	endtask
	task automatic t_uart();
		wr(8'hd2, 8'h00);
		wr(8'ha8, 8'h90);
		wr(8'he0, 8'h01);
		cmp(uflg, 2'b01);
		tick(2);
		cmp(vec, 16'h006b);
		cmp(req, 1'b1);
		wr(8'he0, 8'h00);
		cmp(uflg, 2'b00);
		$display("test uart done");
	endtask
	// ----------------------------------------
	// hardware-set and shared sources
	// ----------------------------------------
	task automatic t_shared();
		urx <= 1'b1;
		tick(1);
		urx <= 1'b0;
		utx <= 1'b1;
		tick(1);
		utx <= 1'b0;
		tick(1);
		cmp(uflg, 2'b11);
		wr(8'he0, 8'h02);
		cmp(uflg, 2'b10);
		wr(8'he0, 8'h00);
		thr <= 1'b1;
		tick(3);
		cmp(req, 1'b0);
		wr(8'ha8, 8'h8a);
		tick(2);
		cmp(vec, 16'h0003);
		spi <= 1'b1;
		wr(8'h8d, 8'h10);
		tick(2);
		cmp(vec, 16'h0073);
		cmp(lvl, 2'd1);
		thr <= 1'b0;
		spi <= 1'b0;
		wr(8'h8d, 8'h00);
		alm <= 1'b1;
		wr(8'ha8, 8'hc0);
		tick(2);
		cmp(vec, 16'h0043);
		cmp(req, 1'b1);
		alm <= 1'b0;
		$display("test shared sources done");
	endtask
	initial begin
		tick(12);
		rst <= 1'b0;
		tick(2);
		t_reset();
		t_gate();
		t_arb();
		t_nest();
		t_ext_a();
		t_ext_b();
		t_uart();
		t_shared();
		test_done();
	end
endmodule
